// ### inc/serial_access_pkg.sv
package serial_access_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLK_HZ          = 50_000_000;
    localparam int SETTLE_TIME_US  = 1000;
    localparam int SETTLE_CYCLES   = (SETTLE_TIME_US * (CLK_HZ / 1_000_000) + 0) < 1 ? 1 :
                                     SETTLE_TIME_US * (CLK_HZ / 1_000_000);
    localparam int ONES_RESET_BITS = 40;

    // ************************************************************
    // command byte layout
    // ************************************************************
    localparam int CMD_RW_BIT       = 6;
    localparam int CMD_ADDR_MSB     = 5;
    localparam int CMD_ADDR_LSB     = 3;
    localparam int CMD_CONTINUOUS_READOUT_ENABLE_BIT    = 2;
    localparam logic [7:0] CMD_EXIT_CONT = 8'h58;

    // ************************************************************
    // register select codes
    // ************************************************************
    localparam logic [2:0] ADDR_CMD_STAT = 3'h0;
    localparam logic [2:0] ADDR_MODE     = 3'h1;
    localparam logic [2:0] ADDR_SETUP    = 3'h2;
    localparam logic [2:0] ADDR_RESULT   = 3'h3;
    localparam logic [2:0] ADDR_IDENT    = 3'h4;
    localparam logic [2:0] ADDR_GPO      = 3'h5;
    localparam logic [2:0] ADDR_ZERO    = 3'h6;
    localparam logic [2:0] ADDR_SPAN     = 3'h7;

    localparam logic [5:0] LEN_BYTE   = 6'h08;
    localparam logic [5:0] LEN_WORD   = 6'h18;
    localparam logic [5:0] LEN_STATUS = 6'h20;

    // ************************************************************
    // status and mode fields, reset values
    // ************************************************************
    localparam logic [7:0]  STATUS_RESET = 8'h80;
    localparam logic [23:0] MODE_RESET   = 24'h080060;
    localparam int MODE_OP_MSB      = 23;
    localparam int MODE_OP_LSB      = 21;
    localparam int MODE_APPEND_BIT  = 20;
    localparam int MODE_CLK_MSB     = 19;
    localparam int MODE_CLK_LSB     = 18;
    localparam int MODE_FILTER_BIT  = 15;
    localparam int MODE_PARITY_BIT  = 13;
    localparam int SETUP_REFDET_BIT = 8;
    localparam logic [1:0] CLK_INT_DRIVEN = 2'h3;

    typedef enum logic [2:0] {
        OP_CONTINUOUS = 3'h0,
        OP_SINGLE     = 3'h1,
        OP_IDLE       = 3'h2,
        OP_POWER_DOWN = 3'h3
    } op_mode_t;

endpackage : serial_access_pkg

// ### core/serial_access.sv
`timescale 1ns/1ps

module serial_access #(
    parameter int         SETTLE_CYCLES = serial_access_pkg::SETTLE_CYCLES,
    parameter logic [7:0] IDENT_VALUE   = 8'h5A  // arbitrary value
) (
    input  wire logic                    clk_sys_i,
    input  wire logic                    rst_i,
    input  wire logic                    sclk_i,
    input  wire logic                    din_i,
    input  wire logic                    sync_n_i,
    input  wire logic                    result_valid_i,
    input  wire logic [23:0]             result_data_i,
    input  wire logic                    result_clamped_i,
    input  wire logic                    ref_low_i,
    input  wire logic [3:0]              channel_i,
    input  wire logic                    pre_update_i,
    output logic                         dout_rdy_o,
    output logic [23:0]                  mode_o,
    output logic [23:0]                  setup_o,
    output logic [7:0]                   gpo_o,
    output logic [23:0]                  zero_scale_o,
    output logic [23:0]                  span_o,
    output logic                         filter_reset_o,
    output logic                         power_down_o,
    output logic                         filter_order_o,
    output logic                         mclk_two_oe_o
);
    import serial_access_pkg::*;

    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 131071) begin : g_bad_settle
        $error("SETTLE_CYCLES out of range");
    end

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [1:0] {
        SER_CMD  = 2'b00,
        SER_XFER = 2'b01,
        SER_CONT = 2'b11
    } ser_state_t;

    typedef enum logic [1:0] {
        CV_FREE    = 2'b00,
        CV_SETTLE  = 2'b01,
        CV_CONVERT = 2'b11,
        CV_DOWN    = 2'b10
    } conv_state_t;

    typedef struct packed {
        logic        sclk_s1;
        logic        sclk_s2;
        logic        sclk_d;
        logic        din_s1;
        logic        din_s2;
        logic        sync_s1;
        logic        sync_s2;
        ser_state_t  ser;
        logic [2:0]  cmd_cnt;
        logic [5:0]  cmd_bits;
        logic        rd;
        logic [2:0]  addr;
        logic        cont;
        logic [5:0]  len;
        logic [5:0]  cnt;
        logic [31:0] shift;
        logic        out_bit;
        logic [5:0]  ones;
        logic        rdy;
        logic        err;
        logic        reference_missing_flag;
        logic        parity;
        logic [3:0]  chan;
        logic [23:0] result;
        logic [23:0] mode;
        logic [23:0] setup;
        logic [7:0]  gpo;
        logic [23:0] zero;
        logic [23:0] span;
        conv_state_t conv;
        logic [16:0] settle;
        logic        dout;
        logic        flt_rst;
        logic        pwr_dn;
        logic        mclk_oe;
    } state_t;

    localparam state_t ST_RST = '{
        sclk_s1: 1'b1, sclk_s2: 1'b1, sclk_d: 1'b1,
        din_s1: 1'b0, din_s2: 1'b0, sync_s1: 1'b1, sync_s2: 1'b1,
        ser: SER_CMD, cmd_cnt: 3'h0, cmd_bits: 6'h00, rd: 1'b0,
        addr: 3'h0, cont: 1'b0, len: 6'h00, cnt: 6'h00, shift: 32'h0000_0000,
        out_bit: 1'b1, ones: 6'h00,
        rdy: STATUS_RESET[7], err: STATUS_RESET[6], reference_missing_flag: STATUS_RESET[5],
        parity: STATUS_RESET[4], chan: STATUS_RESET[3:0],
        result: 24'h000000, mode: MODE_RESET, setup: 24'h000000,
        gpo: 8'h00, zero: 24'h000000, span: 24'h000000,
        conv: CV_FREE, settle: 17'h00000, dout: 1'b1, flt_rst: 1'b0,
        pwr_dn: 1'b0, mclk_oe: 1'b0
    };

    state_t q;
    state_t n;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic       rise;
        logic       fall;
        logic       din;
        logic [6:0] cmd7;
        logic [7:0] status;
        logic [31:0] word;
        logic [23:0] wval;
        logic [23:0] res;
        logic       wr_done;
        logic       rd_done;
        rise    = 1'b0;
        fall    = 1'b0;
        din     = 1'b0;
        cmd7    = 7'h00;
        status  = 8'h00;
        word    = 32'h0000_0000;
        wval    = 24'h000000;
        res     = 24'h000000;
        wr_done = 1'b0;
        rd_done = 1'b0;
        n = q;

        n.sclk_s1 = sclk_i;
        n.sclk_s2 = q.sclk_s1;
        n.sclk_d  = q.sclk_s2;
        n.din_s1  = din_i;
        n.din_s2  = q.din_s1;
        n.sync_s1 = sync_n_i;
        n.sync_s2 = q.sync_s1;
        rise = q.sclk_s2 & ~q.sclk_d;
        fall = ~q.sclk_s2 & q.sclk_d;
        din  = q.din_s2;
        cmd7 = {q.cmd_bits, din};
        status = {q.rdy, q.err, q.reference_missing_flag, q.parity, q.chan};

        wval = {q.shift[22:0], din};

        // command collector: gate bit, then seven bits
        if (rise && (q.ser == SER_CMD || q.cont)) begin
            if (q.cmd_cnt == 3'h0) begin
                if (!din) begin
                    n.cmd_cnt = 3'h1;
                end
            end else begin
                n.cmd_bits = cmd7[5:0];
                n.cmd_cnt  = q.cmd_cnt + 3'h1;
                if (q.cmd_cnt == 3'h7) begin
                    if (q.cont) begin
                        if ({1'b0, cmd7} == CMD_EXIT_CONT) begin
                            n.cont = 1'b0;
                            if (q.ser == SER_CONT) begin
                                n.ser = SER_CMD;
                            end
                        end
                    end else begin
                        n.rd   = cmd7[CMD_RW_BIT];
                        n.addr = cmd7[CMD_ADDR_MSB:CMD_ADDR_LSB];
                        n.cnt  = 6'h00;
                        unique case (cmd7[CMD_ADDR_MSB:CMD_ADDR_LSB])
                            ADDR_CMD_STAT, ADDR_IDENT, ADDR_GPO: n.len = LEN_BYTE;
                            ADDR_RESULT: n.len = q.mode[MODE_APPEND_BIT] ? LEN_STATUS
                                                                         : LEN_WORD;
                            default: n.len = LEN_WORD;
                        endcase
                        if (cmd7[CMD_RW_BIT]) begin
                            if (cmd7[CMD_ADDR_MSB:CMD_ADDR_LSB] == ADDR_RESULT &&
                                cmd7[CMD_CONTINUOUS_READOUT_ENABLE_BIT]) begin
                                n.cont = 1'b1;
                                n.ser  = SER_CONT;
                            end else begin
                                n.ser = SER_XFER;
                            end
                        end else if (cmd7[CMD_ADDR_MSB:CMD_ADDR_LSB] != ADDR_CMD_STAT) begin
                            n.ser = SER_XFER;
                        end
                    end
                end
            end
        end

        // register read image of the address just decoded, left aligned, msb first
        unique case (n.addr)
            ADDR_CMD_STAT: word = {status, 24'h000000};
            ADDR_MODE:     word = {q.mode, 8'h00};
            ADDR_SETUP:    word = {q.setup, 8'h00};
            ADDR_RESULT:   word = {q.result, status};
            ADDR_IDENT:    word = {IDENT_VALUE, 24'h000000};
            ADDR_GPO:      word = {q.gpo, 24'h000000};
            ADDR_ZERO:     word = {q.zero, 8'h00};
            ADDR_SPAN:     word = {q.span, 8'h00};
        endcase

        // msb goes out at once; the shifter keeps the bits after it
        if (q.ser != SER_XFER && n.ser == SER_XFER && n.rd) begin
            n.shift   = {word[30:0], 1'b0};
            n.out_bit = word[31];
        end

        // continuous mode: each new result goes out on sclk
        if (q.ser == SER_CONT && q.cont && !q.rdy) begin
            n.ser     = SER_XFER;
            n.rd      = 1'b1;
            n.addr    = ADDR_RESULT;
            n.cnt     = 6'h00;
            n.len     = q.mode[MODE_APPEND_BIT] ? LEN_STATUS : LEN_WORD;
            n.shift   = {word[30:0], 1'b0};
            n.out_bit = word[31];
        end

        // data phase
        if (q.ser == SER_XFER) begin
            if (q.rd && fall) begin
                n.out_bit = q.shift[31];
                n.shift   = {q.shift[30:0], 1'b0};
            end
            if (rise) begin
                n.cnt = q.cnt + 6'h01;
                if (!q.rd) begin
                    n.shift = {q.shift[30:0], din};
                end
                if (q.cnt == q.len - 6'h01) begin
                    n.ser   = q.cont ? SER_CONT : SER_CMD;
                    wr_done = ~q.rd;
                    rd_done = q.rd;
                end
            end
        end

        // register writes
        n.flt_rst = 1'b0;
        if (wr_done) begin
            unique case (q.addr)
                ADDR_MODE: begin
                    n.mode    = wval;
                    n.flt_rst = 1'b1;
                    n.rdy     = 1'b1;
                    if (wval[MODE_OP_MSB:MODE_OP_LSB] == OP_CONTINUOUS ||
                        wval[MODE_OP_MSB:MODE_OP_LSB] == OP_SINGLE) begin
                        n.err = 1'b0;
                    end
                    if (wval[MODE_OP_MSB:MODE_OP_LSB] == OP_SINGLE) begin
                        n.conv   = CV_SETTLE;
                        n.settle = 17'(SETTLE_CYCLES - 1);
                    end else begin
                        n.conv = CV_FREE;
                    end
                end
                ADDR_SETUP: n.setup = wval;
                ADDR_GPO:   n.gpo   = wval[7:0];
                ADDR_ZERO:  n.zero  = wval;
                ADDR_SPAN:  n.span  = wval;
                default: ;
            endcase
        end

        // single conversion sequence
        unique case (q.conv)
            CV_FREE: ;
            CV_SETTLE: begin
                if (q.settle == 17'h00000) begin
                    n.conv = CV_CONVERT;
                end else begin
                    n.settle = q.settle - 17'h00001;
                end
            end
            CV_CONVERT: begin
                if (result_valid_i) begin
                    n.conv = CV_DOWN;
                end
            end
            CV_DOWN: ;
        endcase

        // ready set events
        if ((rd_done && q.addr == ADDR_RESULT) || pre_update_i || !q.sync_s2) begin
            n.rdy = 1'b1;
        end
        if (wr_done && q.addr == ADDR_MODE &&
            (wval[MODE_OP_MSB:MODE_OP_LSB] == OP_IDLE ||
             wval[MODE_OP_MSB:MODE_OP_LSB] == OP_POWER_DOWN)) begin
            n.rdy = 1'b1;
        end

        // new result: accepted only while the modulator runs
        if (result_valid_i && q.sync_s2 &&
            (q.conv == CV_CONVERT ||
             (q.conv == CV_FREE && q.mode[MODE_OP_MSB:MODE_OP_LSB] == OP_CONTINUOUS))) begin
            n.reference_missing_flag = q.setup[SETUP_REFDET_BIT] & ref_low_i;
            res     = n.reference_missing_flag ? 24'hFFFFFF : result_data_i;
            n.result = res;
            n.rdy    = 1'b0;
            n.err    = result_clamped_i | n.reference_missing_flag;
            n.parity = q.mode[MODE_PARITY_BIT] & (^res);
            n.chan   = channel_i;
        end

        // pin and control outputs
        n.dout    = (n.ser == SER_XFER && n.rd) ? n.out_bit : n.rdy;
        n.pwr_dn  = (n.mode[MODE_OP_MSB:MODE_OP_LSB] == OP_POWER_DOWN) ||
                    (n.conv == CV_DOWN);
        n.mclk_oe = n.mode[MODE_CLK_MSB:MODE_CLK_LSB] == CLK_INT_DRIVEN;
        if (n.mode[MODE_OP_MSB:MODE_OP_LSB] == OP_IDLE || !q.sync_s2) begin
            n.flt_rst = 1'b1;
        end

        // run of ones on data-in resets the whole part
        if (rise) begin
            n.ones = din ? q.ones + 6'h01 : 6'h00;
            if (din && q.ones == 6'(ONES_RESET_BITS - 1)) begin
                n = ST_RST;
                n.sclk_s1 = sclk_i;
                n.sclk_s2 = q.sclk_s1;
                n.sclk_d  = q.sclk_s2;
                n.din_s1  = din_i;
                n.din_s2  = q.din_s1;
                n.sync_s1 = sync_n_i;
                n.sync_s2 = q.sync_s1;
                n.flt_rst = 1'b1;
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            q <= ST_RST;
        end else begin
            q <= n;
        end
    end

    assign dout_rdy_o     = q.dout;
    assign mode_o         = q.mode;
    assign setup_o        = q.setup;
    assign gpo_o          = q.gpo;
    assign zero_scale_o   = q.zero;
    assign span_o         = q.span;
    assign filter_reset_o = q.flt_rst;
    assign power_down_o   = q.pwr_dn;
    assign filter_order_o = q.mode[MODE_FILTER_BIT];
    assign mclk_two_oe_o  = q.mclk_oe;

endmodule : serial_access

// ### bench/serial_access_properties.sv
`timescale 1ns/1ps
// ********************
// port watchers
// ********************
module serial_access_properties
    import serial_access_pkg::*;
(
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic        sync_n_i,
    input wire logic        result_valid_i,
    input wire logic [23:0] result_data_i,
    input wire logic        dout_rdy_o,
    input wire logic [23:0] mode_o,
    input wire logic        filter_reset_o,
    input wire logic        power_down_o,
    input wire logic        filter_order_o,
    input wire logic        mclk_two_oe_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s_idle_held;
        (mode_o[MODE_OP_MSB:MODE_OP_LSB] == OP_IDLE)[*3];
    endsequence
    sequence s_sync_held;
        (!sync_n_i)[*4];
    endsequence
    sequence s_mode_steady;
        $stable(mode_o)[*2];
    endsequence

    AST_RST_VALUES: assert property ($fell(rst_i) |-> mode_o == MODE_RESET && dout_rdy_o)
        else $error("reset values wrong");
    AST_MODE_WRITE: assert property ($changed(mode_o) |-> ##[0:2] filter_reset_o)
        else $error("mode change without filter reset");
    AST_IDLE_HOLD: assert property (s_idle_held |-> filter_reset_o)
        else $error("idle mode without filter reset");
    AST_POWER_DOWN: assert property ((mode_o[23:21] == OP_POWER_DOWN)[*3] |-> power_down_o)
        else $error("power-down mode not shown");
    AST_FILTER_ORDER: assert property (s_mode_steady |-> filter_order_o == mode_o[15])
        else $error("filter order differs from mode");
    AST_CLOCK_PIN: assert property (s_mode_steady |-> mclk_two_oe_o == (mode_o[19:18] == 2'h3))
        else $error("clock pin enable wrong");
    AST_SYNC_READY: assert property (s_sync_held |-> dout_rdy_o && filter_reset_o)
        else $error("sync low without ready set");
    AST_RESULT_READY: assert property (result_valid_i && sync_n_i && $past(sync_n_i, 3)
        && mode_o[23:21] == OP_CONTINUOUS && !result_data_i[23] |-> ##[1:5] !dout_rdy_o)
        else $error("result without ready low");
endmodule : serial_access_properties

bind serial_access serial_access_properties u_props (
    .clk_sys_i, .rst_i, .sync_n_i, .result_valid_i, .result_data_i, .dout_rdy_o,
    .mode_o, .filter_reset_o, .power_down_o, .filter_order_o, .mclk_two_oe_o);

// ### bench/host_model.sv
`timescale 1ns/1ps
// ********************
// host end of the serial link
// ********************
module host_model (
    input  wire logic clk_sys_i,
    input  wire logic dout_rdy_i,
    output logic      sclk_o,
    output logic      din_o
);
    logic q;
    initial begin
        sclk_o = 1'b1;
        din_o  = 1'b0;
    end
    // data out read late in the high phase, before the next falling edge
    task automatic bit_cycle(input logic d);
        sclk_o <= 1'b0;
        din_o  <= d;
        repeat (10) @(posedge clk_sys_i);
        sclk_o <= 1'b1;
        repeat (9) @(posedge clk_sys_i);
        @(negedge clk_sys_i) q = dout_rdy_i;
        @(posedge clk_sys_i);
    endtask : bit_cycle
    task automatic xfer(input int lead, input int nc, input logic [7:0] cmd,
                        input int n, input logic [31:0] wd, output logic [31:0] rd);
        rd = '0;
        @(negedge clk_sys_i) q = dout_rdy_i;
        @(posedge clk_sys_i);
        repeat (lead) bit_cycle(1'b1);
        for (int i = 7; i > 7 - nc; i--) bit_cycle(cmd[i]);
        for (int i = n - 1; i >= 0; i--) begin
            rd[i] = q;
            bit_cycle(wd[i]);
        end
        din_o <= 1'b0;
    endtask : xfer
endmodule : host_model

// ### bench/serial_access_tb.sv
`timescale 1ns/1ps
module serial_access_tb;
    import serial_access_pkg::*;
    localparam logic [7:0] IDENT = 8'h3C; // arbitrary value
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sclk;
    logic        din;
    logic        sync_n = 1'b1;
    logic        rvalid = 1'b0;
    logic [23:0] rdata = '0;
    logic        rclamp = 1'b0;
    logic        ref_low = 1'b0;
    logic [3:0]  chan = '0;
    logic        pre_upd = 1'b0;
    logic        dout, freset, pdn, forder, moe;
    logic [23:0] mode;
    logic [23:0] setup;
    logic [23:0] zscale;
    logic [23:0] span;
    logic [7:0]  gpo;
    logic [31:0] v;
    int          err_count = 0;
    int          comparisons = 0;
    int          cycles = 0;

    always #10 clk = ~clk;

    serial_access #(.SETTLE_CYCLES(20), .IDENT_VALUE(IDENT)) u_dut (
        .clk_sys_i(clk), .rst_i(rst), .sclk_i(sclk), .din_i(din), .sync_n_i(sync_n),
        .result_valid_i(rvalid), .result_data_i(rdata), .result_clamped_i(rclamp),
        .ref_low_i(ref_low), .channel_i(chan), .pre_update_i(pre_upd),
        .dout_rdy_o(dout), .mode_o(mode), .setup_o(setup), .gpo_o(gpo),
        .zero_scale_o(zscale), .span_o(span), .filter_reset_o(freset), .power_down_o(pdn),
        .filter_order_o(forder), .mclk_two_oe_o(moe));
    host_model u_host (.clk_sys_i(clk), .dout_rdy_i(dout), .sclk_o(sclk), .din_o(din));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wreg(input logic [2:0] a, input int n, input logic [31:0] w);
        u_host.xfer(3, 8, {2'b00, a, 3'b000}, n, w, v);
    endtask : wreg
    task automatic rreg(input logic [2:0] a, input int n);
        u_host.xfer(0, 8, {2'b01, a, 3'b000}, n, 32'h0, v);
    endtask : rreg
    task automatic pulse(input logic [23:0] d, input logic [3:0] c, input logic cl);
        @(posedge clk);
        rdata  <= d;
        chan   <= c;
        rclamp <= cl;
        rvalid <= 1'b1;
        @(posedge clk);
        rvalid <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : pulse

    task automatic t_reset();
        u_host.xfer(0, 8, 8'h00, 0, 32'h0, v);
        rreg(ADDR_CMD_STAT, 8);
        chk(v, 32'h80);
        rreg(ADDR_MODE, 24);
        chk(v, 32'h080060);
        $display("reset test done");
    endtask : t_reset
    task automatic t_regs();
        logic [2:0]  a [5] = '{ADDR_MODE, ADDR_SETUP, ADDR_GPO, ADDR_ZERO, ADDR_SPAN};
        int          n [5] = '{24, 24, 8, 24, 24};
        logic [31:0] w [5] = '{32'h0C8060, 32'hA5C23C, 32'h5A, 32'h123456, 32'h654321};
        for (int i = 0; i < 5; i++) begin
            wreg(a[i], n[i], w[i]);
            rreg(a[i], n[i]);
            chk(v, w[i]);
        end
        chk({moe, forder}, 2'b11);
        chk(mode, 32'h0C8060);
        chk(setup, 32'hA5C23C);
        chk(gpo, 32'h5A);
        chk(zscale, 32'h123456);
        chk(span, 32'h654321);
        wreg(ADDR_IDENT, 8, 32'hFF);
        wreg(ADDR_RESULT, 24, 32'hABCDEF);
        rreg(ADDR_IDENT, 8);
        chk(v, IDENT);
        $display("register test done");
    endtask : t_regs
    task automatic t_result();
        pulse(24'h00F00F, 4'h9, 1'b0);
        chk(dout, 1'b0);
        rreg(ADDR_CMD_STAT, 8);
        chk(v, 32'h09);
        rreg(ADDR_RESULT, 24);
        chk(v, 32'h00F00F);
        rreg(ADDR_CMD_STAT, 8);
        chk(v, 32'h89);
        pulse(24'h000001, 4'h9, 1'b0);
        pre_upd <= 1'b1;
        @(posedge clk);
        pre_upd <= 1'b0;
        repeat (6) @(posedge clk);
        chk(dout, 1'b1);
        $display("result test done");
    endtask : t_result
    task automatic t_append();
        wreg(ADDR_MODE, 24, 32'h182060);
        pulse(24'h000007, 4'h3, 1'b1);
        rreg(ADDR_RESULT, 32);
        chk(v, 32'h00000753);
        wreg(ADDR_SETUP, 24, 32'h000100);
        ref_low <= 1'b1;
        pulse(24'h123456, 4'h1, 1'b0);
        ref_low <= 1'b0;
        rreg(ADDR_RESULT, 32);
        chk(v, 32'hFFFFFF61);
        wreg(ADDR_MODE, 24, 32'h182060);
        rreg(ADDR_CMD_STAT, 8);
        chk(v[7:6], 2'b10);
        $display("status append test done");
    endtask : t_append
    task automatic t_cont();
        wreg(ADDR_MODE, 24, 32'h080060);
        pulse(24'hC3A561, 4'h2, 1'b0);
        u_host.xfer(0, 8, 8'h5C, 0, 32'h0, v);
        u_host.xfer(0, 0, 8'h00, 24, 32'h0, v);
        chk(v, 32'hC3A561);
        u_host.xfer(0, 8, CMD_EXIT_CONT, 0, 32'h0, v);
        rreg(ADDR_CMD_STAT, 8);
        chk(v, 32'h82);
        $display("continuous test done");
    endtask : t_cont
    task automatic t_modes();
        wreg(ADDR_MODE, 24, 32'h0C8060);
        u_host.xfer(40, 8, 8'h48, 24, 32'h0, v);
        chk(v, 32'h080060);
        wreg(ADDR_MODE, 24, 32'h480060);
        repeat (4) @(posedge clk);
        chk({freset, dout}, 2'b11);
        wreg(ADDR_MODE, 24, 32'h680060);
        repeat (4) @(posedge clk);
        chk(pdn, 1'b1);
        wreg(ADDR_MODE, 24, 32'h280060);
        chk(pdn, 1'b0);
        repeat (40) @(posedge clk);
        pulse(24'h000100, 4'h5, 1'b0);
        chk({pdn, dout}, 2'b10);
        sync_n <= 1'b0;
        repeat (8) @(posedge clk);
        chk({freset, dout}, 2'b11);
        sync_n <= 1'b1;
        $display("mode test done");
    endtask : t_modes

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            conclude();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_regs();
        t_result();
        t_append();
        t_cont();
        t_modes();
        conclude();
    end
endmodule : serial_access_tb
